// ### include/local_irq_cfg.svh
// Register map, field positions, reset values and timing for the local interrupt handler
// Notes on behaviour
// RQ1 - Thirty-two sources, each enabled and levelled
// RQ2 - Power fail latches on filtered line edge
// RQ3 - System fail latches on active-going edge
// RQ4 - Posted write bus error latches pending
// RQ5 - Abort and external sources have no input
// RQ6 - IRQ1 edge source: own vector, no bus IACK
// RQ7 - Software disables level IRQ1 when edge used
// RQ8 - Own VMEbus request acknowledged latches pending
// RQ9 - Tick timer one and two latch pending
// RQ10 - DMA completion latches pending
// RQ11 - Four global signal bits latch pending
// RQ12 - Two location monitor bits latch pending
// RQ13 - Eight software sources set by register writes
// RQ14 - VMEbus IRQ7-1 sources follow lines directly
// RQ15 - Local acknowledge returns vector unique per source
// RQ16 - Edge pending survives acknowledge; software clears it
// RQ17 - VMEbus source acknowledge runs bus IACK cycle
// RQ18 - Local side follows processor interrupt protocol
// RQ19 - Fixed local base, programmable PCI base, 32-bit
// RQ20 - Short reads allowed; short writes get error
// RQ21 - Software uses read-modify-write for partial updates
// RQ22 - Set and clear bits act on one, read zero
// RQ23 - Auto-clearing bits readable until action completes
// RQ24 - Three-bit level; request needs pending and enable
// RQ25 - Vector is four-bit base plus source number
`ifndef LOCAL_IRQ_CFG_SVH
`define LOCAL_IRQ_CFG_SVH

`define LOCAL_BASE       32'hFFF4_0000
`define OFF_PENDING      8'h68
`define OFF_ENABLE       8'h6C
`define OFF_SWSET        8'h70
`define OFF_CLEAR        8'h74
`define OFF_LVL0         8'h78
`define OFF_LVL1         8'h7C
`define OFF_LVL2         8'h80
`define OFF_LVL3         8'h84
`define OFF_VBASE        8'h88
`define SIZE_LONG        2'b00
`define RESET_ZERO       32'h0000_0000
`define LEVEL_SRC_MASK   32'h0000_007F
`define SW_SET_MASK      32'h0000_FF00
`define CLR_MASK         32'hFFFF_FF00
`define LVL_MASK         32'h7777_7777
`define VBASE_WR_MASK    32'hFF8F_0000
`define SRC_IRQ1_EDGE    5'h1A
`define VME_SRC_LAST     5'h06
`define VB0_LSB          28
`define VB1_LSB          24
`define MST_EN_BIT       23
`define CLK_PERIOD_NS    25
`define ACFAIL_FILTER_NS 100

`endif

// ### include/local_irq_pkg.sv
// Types shared by the local interrupt handler modules
`default_nettype none
package local_irq_pkg;
	typedef logic [2:0]        level_t;
	typedef logic [31:0]       srcvec_t;
	typedef level_t [31:0]     level_arr_t;
	typedef enum logic {ST_IDLE, ST_VME_WAIT} ack_state_e;
	typedef struct packed {
		srcvec_t prev;
		srcvec_t pend;
	} bank_state_s;
	typedef struct packed {
		ack_state_e         st;
		logic [8:0]         sync1;
		logic [8:0]         sync2;
		logic [3:0]         filt_cnt;
		logic               acfail_filt;
		srcvec_t            en;
		logic [3:0][31:0]   lvl;
		logic [31:0]        vreg;
		srcvec_t            set;
		srcvec_t            clr;
		logic               ack;
		logic               transfer_error_ack;
		logic [31:0]        rdata;
		level_t             ipl;
		logic               iack_ack;
		logic               iack_tea;
		logic [7:0]         vector;
		logic               vme_req;
		level_t             vme_lvl;
	} ctl_state_s;
endpackage
`default_nettype wire

// ### include/irq_src_if.sv
// Source vectors passed between the control block, the pending bank and the selector
`timescale 1ns/100ps
`default_nettype none
interface irq_src_if;
	local_irq_pkg::srcvec_t    raw;
	local_irq_pkg::srcvec_t    set;
	local_irq_pkg::srcvec_t    clr;
	local_irq_pkg::srcvec_t    pend;
	local_irq_pkg::srcvec_t    en;
	local_irq_pkg::level_arr_t lvl;
	logic                      mst_en;
	modport bank (input raw, input set, input clr, output pend);
	modport sel  (input pend, input en, input lvl, input mst_en);
	modport ctl  (output raw, output set, output clr, output en, output lvl, output mst_en,
		input pend);
endinterface
`default_nettype wire

// ### hdl/irq_source_bank.sv
// Pending flags: edge latches with set and clear, or direct level followers
`timescale 1ns/100ps
`default_nettype none
`include "local_irq_cfg.svh"
module irq_source_bank (
	input  wire logic clk_i,
	input  wire logic sys_rst_i,
	irq_src_if.bank   src
);
	localparam local_irq_pkg::srcvec_t LVL_SRC = `LEVEL_SRC_MASK;
	local_irq_pkg::bank_state_s q;
	local_irq_pkg::bank_state_s d;
	local_irq_pkg::srcvec_t     nxt;
	local_irq_pkg::srcvec_t     rise_w;
	local_irq_pkg::srcvec_t     keep_w;

	for (genvar n = 0; n < 32; n++) begin : g_src
		assign rise_w[n] = src.raw[n] & ~q.prev[n] & ~LVL_SRC[n];
		assign keep_w[n] = q.pend[n] & ~src.clr[n] & ~LVL_SRC[n];
		// Set beats clear in the same cycle
		assign nxt[n] = LVL_SRC[n] ? src.raw[n] : (keep_w[n] | rise_w[n] | src.set[n]); // [RQ14] [RQ16]
	end

	always_comb begin
		d      = q;
		d.prev = src.raw;
		d.pend = nxt;
	end

	always_ff @(posedge clk_i) begin
		if (sys_rst_i) begin
			q <= '0;
		end else begin
			q <= d;
		end
	end

	assign src.pend = q.pend;

	default clocking @(posedge clk_i); endclocking
	default disable iff (sys_rst_i);
	chk_edge_latch: assert property ((rise_w != '0) |=> ((q.pend & $past(rise_w)) == $past(rise_w))) // [RQ3]
		else $error("edge on a source did not latch pending");
	chk_level_follow: assert property (1'b1 |=> (q.pend[6:0] == $past(src.raw[6:0])))  // [RQ14]
		else $error("level source pending does not follow its line");
	chk_set_wins: assert property ((src.set != '0) |=> ((q.pend & $past(src.set)) == $past(src.set))) // [RQ13]
		else $error("software set was lost");
	chk_pend_held: assert property ((keep_w != '0) |=> ((q.pend & $past(keep_w)) == $past(keep_w))) // [RQ16]
		else $error("edge pending dropped without a clear");
endmodule
`default_nettype wire

// ### hdl/irq_priority_select.sv
// Highest requested level, and the source to answer for an acknowledged level
`timescale 1ns/100ps
`default_nettype none
module irq_priority_select (
	irq_src_if.sel                      src,
	input  wire local_irq_pkg::level_t  query_i,
	output local_irq_pkg::level_t       top_o,
	output logic                        hit_o,
	output logic [4:0]                  src_o
);
	local_irq_pkg::srcvec_t act;

	for (genvar n = 0; n < 32; n++) begin : g_act
		assign act[n] = src.pend[n] & src.en[n] & src.mst_en; // [RQ24]
	end

	// Higher source number wins among equal levels
	always_comb begin
		top_o = '0;
		hit_o = 1'b0;
		src_o = '0;
		for (int n = 0; n < 32; n++) begin
			if (act[n] && (src.lvl[n] > top_o)) begin
				top_o = src.lvl[n];
			end
			if (act[n] && (src.lvl[n] == query_i) && (query_i != '0)) begin
				hit_o = 1'b1;
				src_o = 5'(n);
			end
		end
	end
endmodule
`default_nettype wire

// ### hdl/local_bus_interrupt_handler.sv
// Local bus interrupter and interrupt handler: registers, source capture and acknowledge
`timescale 1ns/100ps
`default_nettype none
`include "local_irq_cfg.svh"
module local_bus_interrupt_handler (
	input  wire logic        clk_i,
	input  wire logic        sys_rst_i,
	// Register access on the local bus
	input  wire logic        bus_req_i,
	input  wire logic        bus_we_i,
	input  wire logic [1:0]  bus_size_i,
	input  wire logic [31:0] bus_addr_i,
	input  wire logic [31:0] bus_wdata_i,
	input  wire logic        pci_space_i,
	input  wire logic [31:0] pci_base_i,
	output logic             bus_ack_o,
	output logic             transfer_error_ack_o,
	output logic [31:0]      bus_rdata_o,
	// Processor interrupt request and acknowledge
	output logic [2:0]       ipl_o,
	input  wire logic        iack_req_i,
	input  wire logic [2:0]  iack_level_i,
	output logic             iack_ack_o,
	output logic             iack_tea_o,
	output logic [7:0]       iack_vector_o,
	// VMEbus lines, active low, asynchronous
	input  wire logic        vme_acfail_n_i,
	input  wire logic        vme_sysfail_n_i,
	input  wire logic [7:1]  vme_irq_n_i,
	// Event sources from neighbouring logic on this clock
	input  wire logic        wp_berr_i,
	input  wire logic        tick1_i,
	input  wire logic        tick2_i,
	input  wire logic        vme_irq_acked_i,
	input  wire logic        dma_done_i,
	input  wire logic [3:0]  sig_i,
	input  wire logic [1:0]  lm_i,
	// VMEbus master IACK request
	output logic             vme_iack_req_o,
	output logic [2:0]       vme_iack_level_o,
	input  wire logic        vme_iack_done_i,
	input  wire logic [7:0]  vme_vector_i
);
	localparam int FILTER_CYC = (`ACFAIL_FILTER_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS;
	localparam logic [3:0] FILTER_CNT = 4'(FILTER_CYC);

	////////////////////////////////////////////////////////////////////////////////
	// State and wiring

	local_irq_pkg::ctl_state_s q;
	local_irq_pkg::ctl_state_s d;
	local_irq_pkg::level_t     sel_top;
	logic                      sel_hit;
	logic [4:0]                sel_src;
	logic                      blk_hit;
	logic                      reg_hit;
	logic [7:0]                reg_off;
	logic                      acfail_s;
	logic                      sysfail_s;
	logic [6:0]                irq_s;
	logic [31:0]               rd_word;
	logic [3:0]                vb_sel;

	irq_src_if srcs ();

	irq_source_bank u_bank (
		.clk_i     (clk_i),
		.sys_rst_i (sys_rst_i),
		.src       (srcs.bank)
	);

	irq_priority_select u_sel (
		.src     (srcs.sel),
		.query_i (iack_level_i),
		.top_o   (sel_top),
		.hit_o   (sel_hit),
		.src_o   (sel_src)
	);

	////////////////////////////////////////////////////////////////////////////////
	// Source assembly

	assign acfail_s  = q.sync2[8];
	assign sysfail_s = q.sync2[7];
	assign irq_s     = q.sync2[6:0];

	assign srcs.raw[31]    = q.acfail_filt;       // [RQ2]
	assign srcs.raw[30]    = 1'b0;                // [RQ5]
	assign srcs.raw[29]    = sysfail_s;           // [RQ3]
	assign srcs.raw[28]    = wp_berr_i;           // [RQ4]
	assign srcs.raw[27]    = 1'b0;                // [RQ5]
	assign srcs.raw[26]    = irq_s[0];            // [RQ6]
	assign srcs.raw[25]    = tick2_i;             // [RQ9]
	assign srcs.raw[24]    = tick1_i;             // [RQ9]
	assign srcs.raw[23]    = vme_irq_acked_i;     // [RQ8]
	assign srcs.raw[22]    = dma_done_i;          // [RQ10]
	assign srcs.raw[21:18] = sig_i;               // [RQ11]
	assign srcs.raw[17:16] = lm_i;                // [RQ12]
	assign srcs.raw[15:8]  = 8'h00;
	assign srcs.raw[7]     = 1'b0;
	assign srcs.raw[6:0]   = irq_s;               // [RQ14]

	assign srcs.set    = q.set;
	assign srcs.clr    = q.clr;
	assign srcs.en     = q.en;                    // [RQ1]
	assign srcs.mst_en = q.vreg[`MST_EN_BIT];

	// Each source's level sits in a four-bit slot, eight sources per register
	for (genvar n = 0; n < 32; n++) begin : g_lvl
		assign srcs.lvl[n] = q.lvl[(31 - n) / 8][(n % 8) * 4 +: 3]; // [RQ1] [RQ24]
	end

	////////////////////////////////////////////////////////////////////////////////
	// Address decode

	assign blk_hit = pci_space_i ? (bus_addr_i[31:8] == pci_base_i[31:8])
		: (bus_addr_i[31:8] == 24'(`LOCAL_BASE >> 8));                // [RQ19]
	assign reg_off = {bus_addr_i[7:2], 2'b00};
	assign reg_hit = blk_hit && (reg_off >= `OFF_PENDING) && (reg_off <= `OFF_VBASE);

	// Read view; set and clear locations read zero
	always_comb begin
		rd_word = `RESET_ZERO;
		case (reg_off)
			`OFF_PENDING: rd_word = srcs.pend;
			`OFF_ENABLE:  rd_word = q.en;
			`OFF_SWSET:   rd_word = `RESET_ZERO;                        // [RQ22]
			`OFF_CLEAR:   rd_word = `RESET_ZERO;                        // [RQ22]
			`OFF_LVL0:    rd_word = q.lvl[0];
			`OFF_LVL1:    rd_word = q.lvl[1];
			`OFF_LVL2:    rd_word = q.lvl[2];
			`OFF_LVL3:    rd_word = q.lvl[3];
			`OFF_VBASE:   rd_word = q.vreg | {9'h000, sysfail_s, acfail_s, 21'h00_0000};
			default:      rd_word = `RESET_ZERO;
		endcase
	end

	assign vb_sel = sel_src[4] ? q.vreg[`VB0_LSB +: 4] : q.vreg[`VB1_LSB +: 4];

	////////////////////////////////////////////////////////////////////////////////
	// Next state

	always_comb begin
		d          = q;
		d.set      = '0;
		d.clr      = '0;
		d.ack      = 1'b0;
		d.transfer_error_ack      = 1'b0;
		d.iack_ack = 1'b0;
		d.iack_tea = 1'b0;

		d.sync1 = {~vme_acfail_n_i, ~vme_sysfail_n_i, ~vme_irq_n_i};
		d.sync2 = q.sync1;

		// Power fail must stay asserted for the filter time before it counts
		if (!acfail_s) begin
			d.filt_cnt    = '0;
			d.acfail_filt = 1'b0;
		end else if (q.filt_cnt == FILTER_CNT) begin
			d.acfail_filt = 1'b1;                                     // [RQ2]
		end else begin
			d.filt_cnt = q.filt_cnt + 4'h1;
		end

		if (bus_req_i && reg_hit) begin
			if (!bus_we_i) begin
				d.ack   = 1'b1;                                       // [RQ20]
				d.rdata = rd_word;
			end else if (bus_size_i != `SIZE_LONG) begin
				d.transfer_error_ack = 1'b1;                                         // [RQ20]
			end else begin
				d.ack = 1'b1;
				case (reg_off)
					`OFF_ENABLE: d.en     = bus_wdata_i;
					`OFF_SWSET:  d.set    = bus_wdata_i & `SW_SET_MASK; // [RQ13] [RQ22]
					`OFF_CLEAR:  d.clr    = bus_wdata_i & `CLR_MASK;    // [RQ22]
					`OFF_LVL0:   d.lvl[0] = bus_wdata_i & `LVL_MASK;
					`OFF_LVL1:   d.lvl[1] = bus_wdata_i & `LVL_MASK;
					`OFF_LVL2:   d.lvl[2] = bus_wdata_i & `LVL_MASK;
					`OFF_LVL3:   d.lvl[3] = bus_wdata_i & `LVL_MASK;
					`OFF_VBASE:  d.vreg   = bus_wdata_i & `VBASE_WR_MASK;
					default:     d.ack    = 1'b1;
				endcase
			end
		end

		d.ipl = sel_top;                                              // [RQ18] [RQ24]

		// Acknowledge never touches pending flags
		case (q.st)
			local_irq_pkg::ST_IDLE: begin
				if (iack_req_i) begin
					if (!sel_hit) begin
						d.iack_tea = 1'b1;
					end else if (sel_src <= `VME_SRC_LAST) begin
						d.st      = local_irq_pkg::ST_VME_WAIT;       // [RQ17]
						d.vme_req = 1'b1;
						d.vme_lvl = sel_src[2:0] + 3'h1;
					end else begin
						d.iack_ack = 1'b1;                            // [RQ6] [RQ15]
						d.vector   = {vb_sel, sel_src[3:0]};          // [RQ25]
					end
				end
			end
			local_irq_pkg::ST_VME_WAIT: begin
				if (vme_iack_done_i) begin
					d.vme_req  = 1'b0;
					d.iack_ack = 1'b1;                                // [RQ17]
					d.vector   = vme_vector_i;
					d.st       = local_irq_pkg::ST_IDLE;
				end
			end
			default: begin
				d.st = local_irq_pkg::ST_IDLE;
			end
		endcase
	end

	always_ff @(posedge clk_i) begin
		if (sys_rst_i) begin
			q <= '0;
		end else begin
			q <= d;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Outputs

	assign bus_ack_o            = q.ack;
	assign transfer_error_ack_o = q.transfer_error_ack;
	assign bus_rdata_o          = q.rdata;
	assign ipl_o                = q.ipl;
	assign iack_ack_o           = q.iack_ack;
	assign iack_tea_o           = q.iack_tea;
	assign iack_vector_o        = q.vector;
	assign vme_iack_req_o       = q.vme_req;
	assign vme_iack_level_o     = q.vme_lvl;

	////////////////////////////////////////////////////////////////////////////////
	// Checks

	default clocking @(posedge clk_i); endclocking
	default disable iff (sys_rst_i);

	chk_short_write_tea: assert property ( // [RQ20]
		(bus_req_i && reg_hit && bus_we_i && (bus_size_i != `SIZE_LONG))
		|=> (transfer_error_ack_o && !bus_ack_o))
		else $error("short write was not refused");

	chk_read_any_size: assert property ( // [RQ20]
		(bus_req_i && reg_hit && !bus_we_i) |=> (bus_ack_o && !transfer_error_ack_o))
		else $error("register read not acknowledged");

	chk_clear_reads_zero: assert property ( // [RQ22]
		(bus_req_i && reg_hit && !bus_we_i && ((reg_off == `OFF_CLEAR) || (reg_off == `OFF_SWSET)))
		|=> (bus_rdata_o == `RESET_ZERO))
		else $error("set or clear location read nonzero");

	chk_ipl_gated: assert property ( // [RQ24]
		(!srcs.mst_en || ((srcs.pend & q.en) == '0)) |=> (ipl_o == 3'h0))
		else $error("interrupt level raised without enabled pending source");

	chk_vme_iack_vector: assert property ( // [RQ17]
		(vme_iack_req_o && vme_iack_done_i)
		|=> (iack_ack_o && !vme_iack_req_o && (iack_vector_o == $past(vme_vector_i))))
		else $error("bus IACK vector not passed back");

	chk_irq1e_local: assert property ( // [RQ6]
		((q.st == local_irq_pkg::ST_IDLE) && iack_req_i && sel_hit && (sel_src == `SRC_IRQ1_EDGE))
		|=> (iack_ack_o && !vme_iack_req_o))
		else $error("IRQ1 edge acknowledge started a bus IACK");

	chk_vme_src_iack: assert property ( // [RQ17]
		((q.st == local_irq_pkg::ST_IDLE) && iack_req_i && sel_hit && (sel_src <= `VME_SRC_LAST))
		|=> (vme_iack_req_o && !iack_ack_o && (vme_iack_level_o == $past(sel_src[2:0]) + 3'h1)))
		else $error("VMEbus source did not request a bus IACK at its level");

	chk_local_vector: assert property ( // [RQ25]
		((q.st == local_irq_pkg::ST_IDLE) && iack_req_i && sel_hit && (sel_src > `VME_SRC_LAST))
		|=> (iack_vector_o[3:0] == $past(sel_src[3:0])))
		else $error("local vector does not carry the source number");

	chk_acfail_filter: assert property ( // [RQ2]
		$rose(q.acfail_filt) |-> ($past(acfail_s, 1) && $past(acfail_s, 2)
			&& $past(acfail_s, 3) && $past(acfail_s, 4)))
		else $error("power fail latched on a short pulse");

	chk_filter_drop: assert property ( // [RQ2]
		!acfail_s |=> !q.acfail_filt)
		else $error("power fail filter held without its line");

	chk_sysfail_latch: assert property ( // [RQ3]
		$rose(sysfail_s) |=> srcs.pend[29])
		else $error("system fail edge did not latch");

	chk_unused_quiet: assert property ( // [RQ5]
		!srcs.pend[30] && !srcs.pend[27] && !srcs.pend[7])
		else $error("unused source became pending");

	chk_swset_pends: assert property ( // [RQ13]
		(bus_req_i && reg_hit && bus_we_i && (bus_size_i == `SIZE_LONG)
			&& (reg_off == `OFF_SWSET))
		|=> ##1 ((srcs.pend & $past(bus_wdata_i, 2) & `SW_SET_MASK)
			== ($past(bus_wdata_i, 2) & `SW_SET_MASK)))
		else $error("software set did not reach pending");

	chk_local_no_bus: assert property ( // [RQ15]
		((q.st == local_irq_pkg::ST_IDLE) && iack_req_i && sel_hit && (sel_src > `VME_SRC_LAST))
		|=> (iack_ack_o && !iack_tea_o && !vme_iack_req_o))
		else $error("local source acknowledge not answered locally");

	chk_vme_wait_hold: assert property ( // [RQ17]
		(vme_iack_req_o && !vme_iack_done_i)
		|=> (vme_iack_req_o && (vme_iack_level_o == $past(vme_iack_level_o))))
		else $error("bus IACK request dropped before it was done");

	chk_spurious_tea: assert property ( // [RQ18]
		((q.st == local_irq_pkg::ST_IDLE) && iack_req_i && !sel_hit)
		|=> (iack_tea_o && !iack_ack_o && !vme_iack_req_o))
		else $error("acknowledge without a source was not refused");

	chk_iack_one_answer: assert property ( // [RQ18]
		!(iack_ack_o && iack_tea_o))
		else $error("acknowledge answered with vector and error at once");

	chk_no_stray_answer: assert property ( // [RQ19]
		!(bus_req_i && reg_hit) |=> (!bus_ack_o && !transfer_error_ack_o))
		else $error("bus answered without a request in the block");

	chk_long_write_ack: assert property ( // [RQ20]
		(bus_req_i && reg_hit && bus_we_i && (bus_size_i == `SIZE_LONG))
		|=> (bus_ack_o && !transfer_error_ack_o))
		else $error("long write not acknowledged");

	chk_refused_no_change: assert property ( // [RQ20]
		(bus_req_i && reg_hit && bus_we_i && (bus_size_i != `SIZE_LONG))
		|=> ((q.en == $past(q.en)) && (q.lvl == $past(q.lvl)) && (q.vreg == $past(q.vreg))))
		else $error("refused write changed a register");

	chk_rdata_held: assert property ( // [RQ20]
		!(bus_req_i && reg_hit && !bus_we_i) |=> $stable(bus_rdata_o))
		else $error("read data changed without a read");

	chk_bus_one_answer: assert property ( // [RQ20]
		!(bus_ack_o && transfer_error_ack_o))
		else $error("bus answered with ack and error at once");
endmodule
`default_nettype wire

// ### tb/cpu_model.sv
// Local processor acknowledge cycles and the VMEbus master IACK responder
`timescale 1ns/100ps
`default_nettype none
module cpu_model (
	input  wire logic       clk_i,
	input  wire logic [3:0] delay_i,
	output logic            iack_req_o,
	output logic [2:0]      iack_level_o,
	input  wire logic       iack_ack_i,
	input  wire logic       iack_tea_i,
	input  wire logic [7:0] iack_vector_i,
	input  wire logic       vme_iack_req_i,
	input  wire logic [2:0] vme_iack_level_i,
	output logic            vme_iack_done_o,
	output logic [7:0]      vme_vector_o
);
	logic busy = 0;
	initial begin
		iack_req_o = 0;
		iack_level_o = 3'h0;
		vme_iack_done_o = 0;
		vme_vector_o = 8'h00;
	end
	////////////////////////////////////////////////////////////////////////////
	// One acknowledge at a time, level held only with the request
	task automatic ack(input logic [2:0] lvl, output logic [7:0] vec, output logic transfer_error_ack);
		int n;
		n = 0;
		@(posedge clk_i);
		#1;
		iack_req_o = 1;
		iack_level_o = lvl;
		@(posedge clk_i);
		#1;
		iack_req_o = 0;
		iack_level_o = ~lvl;
		while (iack_ack_i !== 1'b1 && iack_tea_i !== 1'b1 && n < 40) begin
			@(posedge clk_i);
			#1;
			n++;
		end
		vec = iack_vector_i;
		transfer_error_ack = iack_tea_i;
	endtask
	////////////////////////////////////////////////////////////////////////////
	// Interrupter vector carries the IRQ number; line inverted when idle
	always @(posedge clk_i) begin
		if (vme_iack_req_i === 1'b1 && !busy) begin
			busy = 1;
			repeat (delay_i) @(posedge clk_i);
			#1;
			vme_vector_o = {5'h0B, vme_iack_level_i};
			vme_iack_done_o = 1;
			@(posedge clk_i);
			#1;
			vme_iack_done_o = 0;
			vme_vector_o = ~vme_vector_o;
			busy = 0;
		end
	end
endmodule
`default_nettype wire

// ### tb/testbench.sv
// Self-checking bench for the local bus interrupt handler
`timescale 1ns/100ps
`default_nettype none
`include "local_irq_cfg.svh"
module testbench;
	logic        clk = 0;
	logic        rst = 1;
	logic        req = 0;
	logic        we = 0;
	logic [1:0]  sz = 2'h0;
	logic [31:0] addr = 32'h0000_0000;
	logic [31:0] wd = 32'h0000_0000;
	logic        pci = 0;
	logic        ack, transfer_error_ack, iq, iqa, iqt, vrq, vdn, t;
	logic [31:0] rdata;
	logic [2:0]  ipl, iql, vrl;
	logic [7:0]  ivec, vvec, v;
	logic        acf_n = 1;
	logic        sysf_n = 1;
	logic [7:1]  irq_n = 7'h7F;
	logic [10:0] ev = 11'h000;
	logic [3:0]  dly = 4'h0;
	logic [1:0]  r;
	int          vcnt, vmark;
	int          fail_count = 0;
	int          check_count = 0;
	localparam logic [31:0] WEXP [9] = '{32'h0, 32'hFFFF_FFFF, 32'h0, 32'h0, 32'h7777_7777,
		32'h7777_7777, 32'h7777_7777, 32'h7777_7777, 32'hFF8F_0000};
	always #12.5 clk = ~clk;
	always @(posedge clk) if (vrq === 1'b1) vcnt++;
	local_bus_interrupt_handler uut (.clk_i(clk), .sys_rst_i(rst), .bus_req_i(req),
		.bus_we_i(we), .bus_size_i(sz), .bus_addr_i(addr), .bus_wdata_i(wd),
		.pci_space_i(pci), .pci_base_i(32'h8000_0000), .bus_ack_o(ack),
		.transfer_error_ack_o(transfer_error_ack), .bus_rdata_o(rdata), .ipl_o(ipl), .iack_req_i(iq),
		.iack_level_i(iql), .iack_ack_o(iqa), .iack_tea_o(iqt), .iack_vector_o(ivec),
		.vme_acfail_n_i(acf_n), .vme_sysfail_n_i(sysf_n), .vme_irq_n_i(irq_n),
		.wp_berr_i(ev[10]), .tick1_i(ev[8]), .tick2_i(ev[9]), .vme_irq_acked_i(ev[7]),
		.dma_done_i(ev[6]), .sig_i(ev[5:2]), .lm_i(ev[1:0]), .vme_iack_req_o(vrq),
		.vme_iack_level_o(vrl), .vme_iack_done_i(vdn), .vme_vector_i(vvec));
	cpu_model cpu (.clk_i(clk), .delay_i(dly), .iack_req_o(iq), .iack_level_o(iql),
		.iack_ack_i(iqa), .iack_tea_i(iqt), .iack_vector_i(ivec), .vme_iack_req_i(vrq),
		.vme_iack_level_i(vrl), .vme_iack_done_o(vdn), .vme_vector_o(vvec));
	////////////////////////////////////////////////////////////////////////////
	task automatic cmp_w(input logic [31:0] g, input logic [31:0] e);
		check_count++;
		if (g !== e) begin
			fail_count++;
			$display("unexpected at %0t: word %h, wanted %h", $time, g, e);
		end
	endtask
	task automatic cmp_v(input logic [7:0] g, input logic [7:0] e);
		check_count++;
		if (g !== e) begin
			fail_count++;
			$display("unexpected at %0t: vector %h, wanted %h", $time, g, e);
		end
	endtask
	task automatic tk(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask
	task automatic bus(input logic w, input logic [1:0] s, input logic [7:0] o,
		input logic [31:0] d);
		@(posedge clk);
		#1;
		req = 1;
		we = w;
		sz = s;
		addr = (pci ? 32'h8000_0000 : `LOCAL_BASE) | {24'h00_0000, o};
		wd = d;
		@(posedge clk);
		#1;
		req = 0;
		r = {transfer_error_ack, ack};
	endtask
	task automatic wr(input logic [7:0] o, input logic [31:0] d);
		bus(1, 2'h0, o, d);
		cmp_w({30'h0, r}, 32'h1);
	endtask
	// Line status bits of the control word are masked out
	task automatic rd(input logic [7:0] o, input logic [31:0] e);
		bus(0, 2'h0, o, 32'h0);
		cmp_w({30'h0, r}, 32'h1);
		cmp_w(o == `OFF_VBASE ? rdata & 32'hFF9F_FFFF : rdata, e);
	endtask
	task automatic wrap_up();
		$display("checks %0d, mismatches %0d", check_count, fail_count);
		if (fail_count == 0 && check_count > 0) $display("Regression OK");
		else $display("Regression broken");
		$finish;
	endtask
	////////////////////////////////////////////////////////////////////////////
	initial begin
		tk(6);
		rst = 0;
		for (int i = 0; i < 9; i++) rd(8'h68 + 8'(4 * i), 32'h0);
		for (int i = 0; i < 9; i++) begin
			wr(8'h68 + 8'(4 * i), 32'hFFFF_FFFF);
			rd(8'h68 + 8'(4 * i), WEXP[i]);
		end
		bus(1, 2'h1, `OFF_ENABLE, 32'h0);
		cmp_w({30'h0, r}, 32'h2);
		bus(0, 2'h2, `OFF_ENABLE, 32'h0);
		cmp_w(rdata, 32'hFFFF_FFFF);
		bus(0, 2'h0, 8'h8C, 32'h0);
		cmp_w({30'h0, r}, 32'h0);
		pci = 1;
		rd(`OFF_ENABLE, 32'hFFFF_FFFF);
		pci = 0;
		$display("registers done");
		wr(`OFF_ENABLE, 32'h0);
		wr(`OFF_LVL0, 32'h0000_0605);
		wr(`OFF_LVL1, 32'h0);
		wr(`OFF_LVL2, 32'h0000_0003);
		wr(`OFF_LVL3, 32'h0002_0000);
		wr(`OFF_VBASE, 32'hA380_0000);
		for (int i = 0; i < 11; i++) begin
			ev[i] = 1;
			tk(1);
			ev[i] = 0;
			tk(3);
			rd(`OFF_PENDING, 32'h1 << (i == 10 ? 28 : 16 + i));
			wr(`OFF_CLEAR, 32'hFFFF_FFFF);
			rd(`OFF_PENDING, 32'h0);
		end
		$display("edge sources done");
		acf_n = 0;
		tk(3);
		acf_n = 1;
		tk(12);
		rd(`OFF_PENDING, 32'h0);
		acf_n = 0;
		sysf_n = 0;
		tk(12);
		rd(`OFF_PENDING, 32'hA000_0000);
		acf_n = 1;
		sysf_n = 1;
		tk(6);
		wr(`OFF_CLEAR, 32'hFFFF_FFFF);
		rd(`OFF_PENDING, 32'h0);
		irq_n[5] = 0;
		tk(6);
		wr(`OFF_CLEAR, 32'hFFFF_FFFF);
		rd(`OFF_PENDING, 32'h0000_0010);
		wr(`OFF_ENABLE, 32'h0000_0010);
		for (int d = 0; d < 2; d++) begin
			dly = 4'(5 * d);
			tk(3);
			cmp_w({29'h0, ipl}, 32'h2);
			cpu.ack(3'h2, v, t);
			cmp_v(v, 8'h5D);
		end
		irq_n[5] = 1;
		tk(6);
		rd(`OFF_PENDING, 32'h0);
		$display("pin sources done");
		irq_n[1] = 0;
		tk(6);
		rd(`OFF_PENDING, 32'h0400_0001);
		wr(`OFF_ENABLE, 32'h0400_0000);
		tk(3);
		vmark = vcnt;
		cpu.ack(3'h6, v, t);
		cmp_v(v, 8'hAA);
		cmp_w(32'(vcnt - vmark), 32'h0);
		irq_n[1] = 1;
		wr(`OFF_CLEAR, 32'hFFFF_FFFF);
		$display("edge irq1 done");
		wr(`OFF_ENABLE, 32'h0100_0100);
		ev[8] = 1;
		tk(1);
		ev[8] = 0;
		wr(`OFF_SWSET, 32'h0000_0100);
		tk(3);
		cmp_w({29'h0, ipl}, 32'h5);
		cpu.ack(3'h5, v, t);
		cmp_v(v, 8'hA8);
		rd(`OFF_PENDING, 32'h0100_0100);
		wr(`OFF_CLEAR, 32'h0100_0000);
		tk(3);
		cmp_w({29'h0, ipl}, 32'h3);
		cpu.ack(3'h3, v, t);
		cmp_v(v, 8'h38);
		wr(`OFF_VBASE, 32'hA300_0000);
		tk(3);
		cmp_w({29'h0, ipl}, 32'h0);
		cpu.ack(3'h0, v, t);
		cmp_w({31'h0, t}, 32'h1);
		$display("acknowledge done");
		wrap_up();
	end
	initial begin
		repeat (6000) @(posedge clk);
		fail_count++;
		wrap_up();
	end
endmodule
`default_nettype wire
